/* File: shared/sopa_pkg.sv */
package sopa_pkg;
  // ==========================================
  // Array shape
  localparam int NCELL = 8;
  localparam int NTERM = 8;
  localparam int NROW = 64;
  localparam int NDED = 8;
  localparam int NSIG = 16;
  localparam int NLIT = 32;
  localparam int NPIN = 17;
  localparam int AW = 7;
  localparam int DW = 32;
  // ==========================================
  // Register map, word addresses
  localparam logic [AW-1:0] ADDR_ROW_END = 7'h40;
  localparam logic [AW-1:0] ADDR_DIS_LO = 7'h40;
  localparam logic [AW-1:0] ADDR_DIS_HI = 7'h41;
  localparam logic [AW-1:0] ADDR_ARCH = 7'h42;
  localparam logic [AW-1:0] ADDR_SIG_LO = 7'h43;
  localparam logic [AW-1:0] ADDR_SIG_HI = 7'h44;
  localparam logic [AW-1:0] ADDR_SEC = 7'h45;
  localparam logic [AW-1:0] ADDR_STAT = 7'h46;
  // ==========================================
  // Field positions
  localparam int ARCH_GA = 0;
  localparam int ARCH_GB = 1;
  localparam int ARCH_LOC = 8;
  localparam int ARCH_POL = 16;
  localparam int STAT_OE = 8;
  localparam int STAT_REG = 16;
  localparam int PIN_OE = 16;
  // ==========================================
  // Reset values
  localparam logic [DW-1:0] ROW_RST = 32'hffffffff;
  localparam logic [DW-1:0] WORD_RST = 32'h00000000;
  localparam logic [NPIN-1:0] PIN_RST = 17'h10000;
  localparam logic [NCELL-1:0] OUT_RST = 8'hff;
  // ==========================================
  // Cell modes
  typedef enum logic [2:0] {
    MODE_REG = 3'b000,
    MODE_CIO = 3'b001,
    MODE_COUT = 3'b010,
    MODE_IN = 3'b011,
    MODE_OFF = 3'b100
  } sopa_mode_e;
endpackage : sopa_pkg

/* File: hdl/sopa_array.sv */
module sopa_array (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [sopa_pkg::NDED-1:0] dedIn,
  input wire logic oePin_b,
  input wire logic [sopa_pkg::NCELL-1:0] ioIn,
  output logic [sopa_pkg::NCELL-1:0] ioOut,
  output logic [sopa_pkg::NCELL-1:0] ioOe,
  input wire logic [sopa_pkg::AW-1:0] regAddr,
  input wire logic [sopa_pkg::DW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [sopa_pkg::DW-1:0] regRdData
);
  import sopa_pkg::*;

  // ==========================================
  // Functions
  function automatic logic termEval(
    input logic [NLIT-1:0] conn,
    input logic [NLIT-1:0] lits
  );
    // A connected literal must be high; an all-connected row is always false
    termEval = &(lits | ~conn);
  endfunction : termEval

  function automatic sopa_mode_e modeDecode(
    input logic ga,
    input logic gb,
    input logic lc
  );
    case ({ga, gb, lc})
      3'b010: modeDecode = MODE_REG;
      3'b011: modeDecode = MODE_CIO;
      3'b100: modeDecode = MODE_COUT;
      3'b101: modeDecode = MODE_IN;
      3'b111: modeDecode = MODE_CIO;
      default: modeDecode = MODE_OFF;
    endcase
  endfunction : modeDecode

  // ==========================================
  // Pin synchronisers
  logic [NPIN-1:0] syncA_q;
  logic [NPIN-1:0] syncB_q;
  logic [NPIN-1:0] syncC_q;
  logic [NPIN-1:0] pinLvl_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q <= PIN_RST;
      syncB_q <= PIN_RST;
      syncC_q <= PIN_RST;
    end else begin
      syncA_q <= {oePin_b, ioIn, dedIn};
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  // Level moves only while the last two stages agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinLvl_q <= PIN_RST;
    end else begin
      pinLvl_q <= (syncB_q & syncC_q) | (pinLvl_q & (syncB_q ^ syncC_q));
    end
  end

  // ==========================================
  // Configuration store
  logic [DW-1:0] rowMem_q [NROW];
  logic [NROW-1:0] termDis_q;
  logic globA_q;
  logic globB_q;
  logic [NCELL-1:0] locBit_q;
  logic [NCELL-1:0] polBit_q;
  logic [2*DW-1:0] sigWord_q;
  logic secure_q;
  logic rowHit;

  assign rowHit = regAddr < ADDR_ROW_END;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NROW; i++) begin
        rowMem_q[i] <= ROW_RST;
      end
    end else if (regWr && rowHit) begin
      rowMem_q[regAddr[5:0]] <= regWrData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      termDis_q <= {WORD_RST, WORD_RST};
    end else if (regWr && regAddr == ADDR_DIS_LO) begin
      termDis_q[DW-1:0] <= regWrData;
    end else if (regWr && regAddr == ADDR_DIS_HI) begin
      termDis_q[2*DW-1:DW] <= regWrData;
    end
  end

  // Two global bits plus two bits per cell
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      globA_q <= 1'b0;
      globB_q <= 1'b0;
      locBit_q <= '0;
      polBit_q <= '0;
    end else if (regWr && regAddr == ADDR_ARCH) begin
      globA_q <= regWrData[ARCH_GA];
      globB_q <= regWrData[ARCH_GB];
      locBit_q <= regWrData[ARCH_LOC+:NCELL];
      polBit_q <= regWrData[ARCH_POL+:NCELL];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sigWord_q <= {WORD_RST, WORD_RST};
    end else if (regWr && regAddr == ADDR_SIG_LO) begin
      sigWord_q[DW-1:0] <= regWrData;
    end else if (regWr && regAddr == ADDR_SIG_HI) begin
      sigWord_q[2*DW-1:DW] <= regWrData;
    end
  end

  // Security only sets; like an erase, only reset clears it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      secure_q <= 1'b0;
    end else if (regWr && regAddr == ADDR_SEC && regWrData[0]) begin
      secure_q <= 1'b1;
    end
  end

  // ==========================================
  // Array
  sopa_mode_e cellMode [NCELL];
  logic [NCELL-1:0] fbSig;
  logic [NLIT-1:0] lits;
  logic [NROW-1:0] termVec;
  logic [NCELL-1:0] sumVec;
  logic [NCELL-1:0] oeVec;
  logic [NCELL-1:0] cellReg_q;
  logic [NCELL-1:0] ioOut_q;
  logic [NCELL-1:0] ioOe_q;

  always_comb begin
    for (int c = 0; c < NCELL; c++) begin
      cellMode[c] = modeDecode(globA_q, globB_q, locBit_q[c]);
    end
  end

  // Feedback reads only flops, so the array holds no loop
  always_comb begin
    for (int c = 0; c < NCELL; c++) begin
      case (cellMode[c])
        MODE_REG: fbSig[c] = cellReg_q[c];
        MODE_CIO: fbSig[c] = pinLvl_q[NDED+c];
        MODE_IN: fbSig[c] = pinLvl_q[NDED+c];
        MODE_COUT: fbSig[c] = pinLvl_q[NDED+(c^1)];
        default: fbSig[c] = 1'b0;
      endcase
    end
  end

  always_comb begin
    for (int s = 0; s < NSIG; s++) begin
      if (s < NDED) begin
        lits[2*s] = pinLvl_q[s];
        lits[2*s+1] = ~pinLvl_q[s];
      end else begin
        lits[2*s] = fbSig[s-NDED];
        lits[2*s+1] = ~fbSig[s-NDED];
      end
    end
  end

  always_comb begin
    for (int k = 0; k < NROW; k++) begin
      termVec[k] = ~termDis_q[k] & termEval(rowMem_q[k], lits);
    end
  end

  always_comb begin
    for (int c = 0; c < NCELL; c++) begin
      sumVec[c] = |termVec[c*NTERM+1+:NTERM-1];
      if (cellMode[c] != MODE_CIO) begin
        sumVec[c] = sumVec[c] | termVec[c*NTERM];
      end
      case (cellMode[c])
        MODE_REG: oeVec[c] = ~pinLvl_q[PIN_OE];
        MODE_CIO: oeVec[c] = termVec[c*NTERM];
        MODE_COUT: oeVec[c] = 1'b1;
        MODE_IN: oeVec[c] = 1'b0;
        default: oeVec[c] = 1'b0;
      endcase
    end
  end

  // All cell registers share clk; only registered cells use them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cellReg_q <= '0;
    end else begin
      cellReg_q <= sumVec;
    end
  end

  // Pin tracks the same sum as the register, so in registered mode it equals it when polBit_q is set, its inverse when clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ioOut_q <= OUT_RST;
      ioOe_q <= '0;
    end else begin
      ioOut_q <= sumVec ^ ~polBit_q;
      ioOe_q <= oeVec;
    end
  end

  assign ioOut = ioOut_q;
  assign ioOe = ioOe_q;

  // ==========================================
  // Register readback
  logic [DW-1:0] rdData_d;
  logic [DW-1:0] rdData_q;

  always_comb begin
    rdData_d = WORD_RST;
    if (rowHit) begin
      rdData_d = secure_q ? WORD_RST : rowMem_q[regAddr[5:0]];
    end else begin
      case (regAddr)
        ADDR_DIS_LO: rdData_d = secure_q ? WORD_RST : termDis_q[DW-1:0];
        ADDR_DIS_HI: rdData_d = secure_q ? WORD_RST : termDis_q[2*DW-1:DW];
        ADDR_ARCH: begin
          if (!secure_q) begin
            rdData_d[ARCH_GA] = globA_q;
            rdData_d[ARCH_GB] = globB_q;
            rdData_d[ARCH_LOC+:NCELL] = locBit_q;
            rdData_d[ARCH_POL+:NCELL] = polBit_q;
          end
        end
        ADDR_SIG_LO: rdData_d = sigWord_q[DW-1:0];
        ADDR_SIG_HI: rdData_d = sigWord_q[2*DW-1:DW];
        ADDR_SEC: rdData_d[0] = secure_q;
        ADDR_STAT: begin
          rdData_d[NCELL-1:0] = ioOut_q;
          rdData_d[STAT_OE+:NCELL] = ioOe_q;
          rdData_d[STAT_REG+:NCELL] = cellReg_q;
        end
        default: rdData_d = WORD_RST;
      endcase
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_q <= WORD_RST;
    end else if (regRd) begin
      rdData_q <= rdData_d;
    end else begin
      rdData_q <= WORD_RST;
    end
  end

  assign regRdData = rdData_q;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence sRowRead;
    regRd && rowHit && secure_q;
  endsequence

  sequence sSigRead;
    regRd && regAddr == ADDR_SIG_LO;
  endsequence

  sequence sRegSteady;
    cellMode[0] == MODE_REG && $stable(polBit_q[0]) && $stable(globA_q);
  endsequence

  chk_secure_read: assert property (
    sRowRead |=> regRdData == WORD_RST
  ) else $error("Pattern readback while secured");

  chk_sig_read: assert property (
    sSigRead |=> regRdData == $past(sigWord_q[DW-1:0])
  ) else $error("Signature readback wrong");

  chk_reg_pin: assert property (
    sRegSteady ##0 $stable(locBit_q[0]) |-> ioOut_q[0] == (cellReg_q[0] ^ ~polBit_q[0])
  ) else $error("Registered pin differs from register");

  chk_reg_feed: assert property (
    cellMode[0] == MODE_REG |=> cellReg_q[0] == $past(sumVec[0])
  ) else $error("Register missed the sum");

  chk_ext_enable: assert property (
    cellMode[1] == MODE_REG |=> ioOe_q[1] == !$past(pinLvl_q[PIN_OE])
  ) else $error("Registered enable not from pin");

  chk_term_enable: assert property (
    cellMode[2] == MODE_CIO |=> ioOe_q[2] == $past(termVec[2*NTERM])
  ) else $error("Term enable not followed");

  chk_input_off: assert property (
    cellMode[3] == MODE_IN ##1 cellMode[3] == MODE_IN |-> !ioOe_q[3]
  ) else $error("Input cell drives its pin");

  chk_output_on: assert property (
    cellMode[4] == MODE_COUT |=> ioOe_q[4]
  ) else $error("Dedicated output not enabled");

  chk_term_kill: assert property (
    termDis_q[NTERM-1:0] == '1 |-> sumVec[0] == 1'b0
  ) else $error("Disabled terms still in sum");

  chk_adj_feed: assert property (
    cellMode[5] == MODE_COUT |-> fbSig[5] == pinLvl_q[NDED+4]
  ) else $error("Neighbour feedback wrong");

  chk_rd_idle: assert property (
    !regRd |=> regRdData == WORD_RST
  ) else $error("Read data outside its cycle");

endmodule : sopa_array

/* File: bench/sopa_board.sv */
module sopa_board (
  input wire logic [sopa_pkg::NCELL-1:0] ioOut,
  input wire logic [sopa_pkg::NCELL-1:0] ioOe,
  input wire logic [sopa_pkg::NCELL-1:0] extEn,
  input wire logic [sopa_pkg::NCELL-1:0] extVal,
  output logic [sopa_pkg::NCELL-1:0] ioIn
);
  timeunit 1ns;
  timeprecision 1ns;
  import sopa_pkg::*;
  // ==========================================
  // Pin resolution
  // A released pin floats high on its pull-up, never to the last value
  always_comb begin
    for (int i = 0; i < NCELL; i++) begin
      if (ioOe[i]) begin
        ioIn[i] = ioOut[i];
      end else if (extEn[i]) begin
        ioIn[i] = extVal[i];
      end else begin
        ioIn[i] = 1'b1;
      end
    end
  end
endmodule : sopa_board

/* File: bench/test_configurable_sum_of_products_array.sv */
module test_configurable_sum_of_products_array;
  timeunit 1ns;
  timeprecision 1ns;
  import sopa_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [NDED-1:0] dedIn = '0;
  logic oePin_b = 1'b0;
  logic [NCELL-1:0] ioIn;
  logic [NCELL-1:0] ioOut;
  logic [NCELL-1:0] ioOe;
  logic [NCELL-1:0] extEn = '0;
  logic [NCELL-1:0] extVal = '0;
  logic [AW-1:0] regAddr = '0;
  logic [DW-1:0] regWrData = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DW-1:0] regRdData;
  logic [DW-1:0] rdVal;
  logic [DW-1:0] archTab [2] = '{32'h00ffff03, 32'h00ffff02};
  int miscompares = 0;
  int totalChecks = 0;
  // ==========================================
  // Clock and design
  initial begin
    forever #50 clk = ~clk;
  end
  sopa_array sopa_array_inst (.clk(clk), .rst_b(rst_b), .dedIn(dedIn), .oePin_b(oePin_b),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  sopa_board sopa_board_inst (.ioOut(ioOut), .ioOe(ioOe), .extEn(extEn), .extVal(extVal),
    .ioIn(ioIn));
  // ==========================================
  // Bus and check tasks
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    rdVal = regRdData;
  endtask : rd
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Pins pass a four-flop filter, so allow margin past its four edges
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask : settle
  task automatic st(input logic [DW-1:0] m, input logic [DW-1:0] exp);
    rd(ADDR_STAT);
    check(rdVal & m, exp);
    check({16'h0000, ioOe, ioOut} & m, exp & 32'h0000ffff);
  endtask : st
  task automatic stop_test();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  // ==========================================
  // Tests
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    st(32'hffffffff, 32'h000000ff);
    rd(7'h00);
    check(rdVal, ROW_RST);
    rd(7'h47);
    check(rdVal, 32'h00000000);
    wr(7'h00, 32'h00000001);
    wr(7'h08, 32'h00010000);
    wr(ADDR_ARCH, 32'h00000002);
    settle();
    st(32'hffffffff, 32'h0000ffff);
    @(posedge clk);
    dedIn <= 8'h01;
    settle();
    st(32'hffffffff, 32'h0003fffc);
    wr(ADDR_DIS_LO, 32'h000000ff);
    settle();
    st(32'hffffffff, 32'h0000ffff);
    @(posedge clk);
    oePin_b <= 1'b1;
    settle();
    st(32'hffffffff, 32'h000000ff);
    wr(ADDR_DIS_LO, 32'h00000000);
    wr(ADDR_ARCH, 32'h00010002);
    settle();
    st(32'hffffffff, 32'h000300fd);
    wr(7'h08, 32'h00040000);
    wr(ADDR_ARCH, 32'h00ff0001);
    settle();
    st(32'h0000ffff, 32'h0000ff03);
    // Cell 1 must follow its neighbour's pin, so the change crosses two pin filters
    @(posedge clk);
    dedIn <= 8'h00;
    settle();
    settle();
    st(32'h0000ffff, 32'h0000ff00);
    wr(7'h08, ROW_RST);
    wr(7'h00, 32'h00010000);
    wr(ADDR_ARCH, 32'h00ffff01);
    @(posedge clk);
    extEn <= 8'h01;
    extVal <= 8'h01;
    settle();
    st(32'h0000ffff, 32'h00000001);
    @(posedge clk);
    extVal <= 8'h00;
    settle();
    st(32'h0000ffff, 32'h00000000);
    wr(7'h00, 32'h00000001);
    @(posedge clk);
    extEn <= 8'h00;
    foreach (archTab[i]) begin
      wr(ADDR_ARCH, archTab[i]);
      rd(ADDR_ARCH);
      check(rdVal, archTab[i]);
      @(posedge clk);
      dedIn <= 8'h01;
      settle();
      st(32'h0000ffff, 32'h00000100);
      @(posedge clk);
      dedIn <= 8'h00;
      settle();
      st(32'h0000ffff, 32'h00000000);
    end
    wr(ADDR_SIG_LO, 32'h89abcdef);
    wr(ADDR_SIG_HI, 32'h01234567);
    wr(ADDR_SEC, 32'h00000001);
    wr(ADDR_SEC, 32'h00000000);
    rd(ADDR_SIG_HI);
    check(rdVal, 32'h01234567);
    rd(ADDR_SIG_LO);
    check(rdVal, 32'h89abcdef);
    rd(7'h00);
    check(rdVal, 32'h00000000);
    rd(ADDR_ARCH);
    check(rdVal, 32'h00000000);
    stop_test();
  end
  // A hang ends the run after far longer than the tests need
  initial begin
    #500000;
    miscompares++;
    stop_test();
  end
endmodule : test_configurable_sum_of_products_array
